// ===== src/adcc_defines.svh
/*
  Offsets, field positions, reset values and cycle counts of the converter
  control block. Assumes inclusion by bare name from the design files.
*/
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define ADCC_IDX_RES_LOW   3'h0
`define ADCC_IDX_RES_HIGH  3'h1
`define ADCC_IDX_CTRL2     3'h2
`define ADCC_IDX_CSR       3'h3
`define ADCC_IDX_MUX       3'h4

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ADCC_CSR_EN        7
`define ADCC_CSR_START     6
`define ADCC_CSR_ATE       5
`define ADCC_CSR_FLAG      4
`define ADCC_CSR_IE        3
`define ADCC_MUX_REF_LSB   6
`define ADCC_MUX_TOUCH_LSB 4
`define ADCC_CTRL2_LADJ    3

// ------------------------------------------------------------
// Reset values, responses and cycle counts
// ------------------------------------------------------------
`define ADCC_RST_BYTE      8'h00
`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2
`define ADCC_CYC_NORMAL    5'h0D
`define ADCC_CYC_LONG      5'h19

`endif

// ===== src/adcc_pkg.sv
/*
  Types of the converter control block.
  Assumes the defines header is compiled alongside.
*/
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_ST_IDLE = 2'b01,
    ADCC_ST_CONV = 2'b10
  } adcc_state_t;

  typedef enum logic [1:0] {
    ADCC_REF_SUPPLY   = 2'b00,
    ADCC_REF_EXTERNAL = 2'b01,
    ADCC_REF_INTERNAL = 2'b10,
    ADCC_REF_RESERVED = 2'b11
  } adcc_ref_t;

endpackage

// ===== src/adcc_clk_div.sv
/*
  Converter clock divider: one-cycle tick every 2..128 system clocks.
  Assumes the divide code comes from a register on the same clock.
*/
`timescale 1ns/1ps

module adcc_clk_div
  import adcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  output logic            tick
);

  logic [6:0] cnt_reg;
  logic [6:0] last;

  // ------------------------------------------------------------
  // Division factor
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (div_code)
      3'h0, 3'h1: last = 7'h01;
      3'h2:       last = 7'h03;
      3'h3:       last = 7'h07;
      3'h4:       last = 7'h0F;
      3'h5:       last = 7'h1F;
      3'h6:       last = 7'h3F;
      3'h7:       last = 7'h7F;
    endcase
  end

  // ------------------------------------------------------------
  // Counter and tick
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || !run)
    begin
      cnt_reg <= 7'h00;
      tick    <= 1'b0;
    end
    else if (cnt_reg >= last)
    begin
      cnt_reg <= 7'h00;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 7'h01;
      tick    <= 1'b0;
    end
  end

endmodule // adcc_clk_div

// ===== src/adcc_top.sv
/*
  Control and register logic of a 10-bit converter, reached over AXI4-Lite.
  Assumes an analog core that samples on core_sample and returns its result
  with a core_done strobe before the conversion count ends.
*/
`timescale 1ns/1ps
`include "adcc_defines.svh"

// Summary of operation
// - Two-bit reference field: supply, external pin, internal 1.1V, reserved.
// - Reference write during conversion applies only after that conversion.
// - After any reference change the next conversion lasts 25 converter clocks.
// - Four-bit channel field: inputs 0-11, ground, reference, temperature, reserved.
// - Channel write during conversion applies only after that conversion.
// - Enable one turns converter on; zero turns off and aborts conversion.
// - Single mode: start per conversion; free running: one start, then automatic.
// - First conversion after enabling takes 25 clocks; normal ones take 13.
// - Start bit reads one while converting; writing zero does nothing.
// - With auto-trigger on, rising edge of selected trigger starts conversion.
// - Done flag sets when conversion finishes, also while the read lock keeps the result from updating.
// - Done flag clears on interrupt vector or write of one.
// - Interrupt requested when flag, enable bit and global enable are set.
// - Three-bit divider code: 2,2,4,8,16,32,64,128 system clocks.
// - After low byte read, results are held until high byte read.
// - Justify clear: high holds 9:8, low 7:0; set: high 9:2, low 1:0.
// - Trigger source field: 000 free running, others select trigger inputs.
// - Justify bit changes presentation immediately, even mid-conversion.
module adcc_top
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              global_irq_enable,
  input  wire logic              irq_vector_ack,
  input  wire logic [6:0]        trigger_inputs,
  output logic                   conversion_done_irq,
  output logic                   core_sample,
  output logic                   core_long,
  output logic [3:0]             core_input_channel_select,
  output logic [1:0]             core_reference_select,
  output logic                   core_clk_tick,
  input  wire logic [9:0]        core_result,
  input  wire logic              core_done
);

  generate
    if (ADDR_W < 5)
    begin : g_bad_addr
      $error("adcc_top: ADDR_W must be at least 5");
    end
  endgenerate

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[ADDR_W-1:2] <= ADDR_W'(`ADCC_IDX_MUX)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [7:0] res_byte(input logic [9:0] r, input logic ladj, input logic high);
    if (high)
      res_byte = ladj ? r[9:2] : {6'h00, r[9:8]};
    else
      res_byte = ladj ? {r[1:0], 6'h00} : r[7:0];
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [1:0]  reference_select_reg;
  logic [1:0]  reserved_touch_reg;
  logic [3:0]  input_channel_select_reg;
  logic        converter_enable_reg;
  logic        auto_trigger_enable_reg;
  logic        conversion_done_flag_reg;
  logic        conversion_done_irq_enable_reg;
  logic [2:0]  converter_clock_divider_reg;
  logic        result_left_justify_reg;
  logic [2:0]  trigger_source_select_reg;
  logic [9:0]  result_reg;
  logic [9:0]  sample_reg;
  logic        lock_reg;
  logic        first_pending_reg;
  logic        ref_changed_reg;
  logic        trig_prev_reg;
  logic [4:0]  cyc_cnt_reg;
  adcc_state_t state_reg;

  // Bus holding registers
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_have_reg;
  logic [7:0]        w_data_reg;
  logic              w_lane0_reg;
  logic              w_have_reg;

  // ------------------------------------------------------------
  // Decode of the write and read in progress
  // ------------------------------------------------------------
  logic       wr_fire;
  logic [2:0] wr_idx;
  logic       wr_ok;
  logic       csr_wr;
  logic       mux_wr;
  logic       ctl2_wr;
  logic       en_next;
  logic       sw_start;
  logic [2:0] rd_idx;
  logic       rd_fire;

  assign wr_fire  = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_idx   = aw_addr_reg[4:2];
  assign wr_ok    = wr_fire && mapped(aw_addr_reg) && w_lane0_reg;
  assign csr_wr   = wr_ok && (wr_idx == `ADCC_IDX_CSR);
  assign mux_wr   = wr_ok && (wr_idx == `ADCC_IDX_MUX);
  assign ctl2_wr  = wr_ok && (wr_idx == `ADCC_IDX_CTRL2);
  assign en_next  = csr_wr ? w_data_reg[`ADCC_CSR_EN] : converter_enable_reg;
  // Zero in the start position is simply ignored
  assign sw_start = csr_wr && w_data_reg[`ADCC_CSR_START] && w_data_reg[`ADCC_CSR_EN];
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign rd_idx   = s_axi_araddr[4:2];

  // ------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------
  logic       trig_sel;
  logic       auto_start;
  logic       conv_last;
  logic       done;
  logic       free_restart;
  logic       start_go;
  logic       idle;
  logic       long_go;

  assign idle      = (state_reg == ADCC_ST_IDLE);
  // Source zero is free running and never produces an edge
  assign trig_sel  = (trigger_source_select_reg == 3'h0) ? 1'b0
                     : trigger_inputs[trigger_source_select_reg - 3'h1];
  assign auto_start = auto_trigger_enable_reg && trig_sel && !trig_prev_reg;
  assign conv_last = (cyc_cnt_reg == ((core_long ? `ADCC_CYC_LONG : `ADCC_CYC_NORMAL) - 5'h01));
  assign done      = (state_reg == ADCC_ST_CONV) && core_clk_tick && conv_last && en_next;
  assign free_restart = done && auto_trigger_enable_reg && (trigger_source_select_reg == 3'h0);
  assign start_go  = en_next && ((idle && (sw_start || auto_start)) || free_restart);
  assign long_go   = first_pending_reg || ref_changed_reg || (csr_wr && !converter_enable_reg);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= trig_sel;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg   <= ADCC_ST_IDLE;
      cyc_cnt_reg <= 5'h00;
    end
    else if (!en_next)
    begin
      state_reg   <= ADCC_ST_IDLE;
      cyc_cnt_reg <= 5'h00;
    end
    else if (start_go)
    begin
      state_reg   <= ADCC_ST_CONV;
      cyc_cnt_reg <= 5'h00;
    end
    else if (done)
    begin
      state_reg   <= ADCC_ST_IDLE;
      cyc_cnt_reg <= 5'h00;
    end
    else if ((state_reg == ADCC_ST_CONV) && core_clk_tick)
      cyc_cnt_reg <= cyc_cnt_reg + 5'h01;
  end

  // First-conversion and reference-change markers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      first_pending_reg <= 1'b0;
    else if (csr_wr && w_data_reg[`ADCC_CSR_EN] && !converter_enable_reg)
      first_pending_reg <= !start_go;
    else if (!converter_enable_reg || start_go)
      first_pending_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ref_changed_reg <= 1'b0;
    else if (mux_wr && (w_data_reg[`ADCC_MUX_REF_LSB +: 2] != reference_select_reg))
      ref_changed_reg <= 1'b1;
    else if (start_go)
      ref_changed_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // Core request; settings latched only at conversion start
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_sample               <= 1'b0;
      core_long                 <= 1'b0;
      core_input_channel_select <= 4'h0;
      core_reference_select     <= 2'h0;
    end
    else
    begin
      core_sample <= start_go;
      if (start_go)
      begin
        core_long                 <= long_go;
        core_input_channel_select <= input_channel_select_reg;
        core_reference_select     <= reference_select_reg;
      end
    end
  end

  adcc_clk_div u_clk_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .run      (converter_enable_reg),
    .div_code (converter_clock_divider_reg),
    .tick     (core_clk_tick)
  );

  // ------------------------------------------------------------
  // Result capture and read lock
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sample_reg <= 10'h000;
    else if (core_done && (state_reg == ADCC_ST_CONV))
      sample_reg <= core_result;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      result_reg <= 10'h000;
    else if (done && !lock_reg)
      result_reg <= core_done ? core_result : sample_reg;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lock_reg <= 1'b0;
    else if (rd_fire && mapped(s_axi_araddr) && (rd_idx == `ADCC_IDX_RES_LOW))
      lock_reg <= 1'b1;
    else if (rd_fire && mapped(s_axi_araddr) && (rd_idx == `ADCC_IDX_RES_HIGH))
      lock_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // Done flag and interrupt request
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      conversion_done_flag_reg <= 1'b0;
    else if (done)
      conversion_done_flag_reg <= 1'b1;
    else if (irq_vector_ack || (csr_wr && w_data_reg[`ADCC_CSR_FLAG]))
      conversion_done_flag_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      conversion_done_irq <= 1'b0;
    else
      conversion_done_irq <= conversion_done_flag_reg && conversion_done_irq_enable_reg
                             && global_irq_enable;
  end

  // ------------------------------------------------------------
  // Software-written fields
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      converter_enable_reg           <= 1'b0;
      auto_trigger_enable_reg        <= 1'b0;
      conversion_done_irq_enable_reg <= 1'b0;
      converter_clock_divider_reg    <= 3'h0;
    end
    else if (csr_wr)
    begin
      converter_enable_reg           <= w_data_reg[`ADCC_CSR_EN];
      auto_trigger_enable_reg        <= w_data_reg[`ADCC_CSR_ATE];
      conversion_done_irq_enable_reg <= w_data_reg[`ADCC_CSR_IE];
      converter_clock_divider_reg    <= w_data_reg[2:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reference_select_reg     <= 2'h0;
      reserved_touch_reg       <= 2'h0;
      input_channel_select_reg <= 4'h0;
    end
    else if (mux_wr)
    begin
      reference_select_reg     <= w_data_reg[`ADCC_MUX_REF_LSB +: 2];
      reserved_touch_reg       <= w_data_reg[`ADCC_MUX_TOUCH_LSB +: 2];
      input_channel_select_reg <= w_data_reg[3:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      result_left_justify_reg   <= 1'b0;
      trigger_source_select_reg <= 3'h0;
    end
    else if (ctl2_wr)
    begin
      result_left_justify_reg   <= w_data_reg[`ADCC_CTRL2_LADJ];
      trigger_source_select_reg <= w_data_reg[2:0];
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channels
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
    else if (wr_fire)
      aw_have_reg   <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      w_have_reg   <= 1'b0;
      w_data_reg   <= `ADCC_RST_BYTE;
      w_lane0_reg  <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata[7:0];
      w_lane0_reg  <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
    else if (wr_fire)
      w_have_reg   <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ADCC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_reg) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channels
  // ------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = `ADCC_RST_BYTE;
    unique case (rd_idx)
      `ADCC_IDX_RES_LOW:  rd_byte = res_byte(result_reg, result_left_justify_reg, 1'b0);
      `ADCC_IDX_RES_HIGH: rd_byte = res_byte(result_reg, result_left_justify_reg, 1'b1);
      `ADCC_IDX_CTRL2:    rd_byte = {4'h0, result_left_justify_reg, trigger_source_select_reg};
      `ADCC_IDX_CSR:      rd_byte = {converter_enable_reg, !idle, auto_trigger_enable_reg,
                                     conversion_done_flag_reg, conversion_done_irq_enable_reg,
                                     converter_clock_divider_reg};
      `ADCC_IDX_MUX:      rd_byte = {reference_select_reg, reserved_touch_reg, input_channel_select_reg};
      default:            rd_byte = `ADCC_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ADCC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= mapped(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h0000_0000;
      s_axi_rresp   <= mapped(s_axi_araddr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // adcc_top

// ===== dv/adcc_top_properties.sv
/*
  Port checker of adcc_top, bound to every instance of it.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/1ps

module adcc_top_properties
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        global_irq_enable,
  input wire logic        irq_vector_ack,
  input wire logic        conversion_done_irq,
  input wire logic        core_sample,
  input wire logic        core_clk_tick,
  input wire logic [3:0]  core_input_channel_select,
  input wire logic [1:0]  core_reference_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after request");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  a_slverr_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_irq_masked: assert property (!global_irq_enable |=> !conversion_done_irq)
    else $error("interrupt with global enable low");
  a_irq_ack_clear: assert property (irq_vector_ack |-> ##2 !conversion_done_irq)
    else $error("interrupt survives vector acknowledge");
  a_tick_gap: assert property (core_clk_tick |=> !core_clk_tick)
    else $error("converter clock faster than half rate");
  a_chan_hold: assert property (!core_sample |-> $stable(core_input_channel_select))
    else $error("channel moved outside a conversion start");
  a_ref_hold: assert property (!core_sample |-> $stable(core_reference_select))
    else $error("reference moved outside a conversion start");
  a_sample_gap: assert property (core_sample |=> !core_sample [*4])
    else $error("conversion restarted too soon");
endmodule // adcc_top_properties

bind adcc_top adcc_top_properties u_props (.*);

// ===== dv/adcc_core_model.sv
/*
  Behavioural converter core: latches a value at each sample request
  and returns it with a done strobe a few converter clocks later.
*/
`timescale 1ns/1ps

module adcc_core_model
(
  input  wire logic       clk,
  input  wire logic       core_sample,
  input  wire logic       core_clk_tick,
  input  wire logic [9:0] value,
  output logic [9:0]      core_result,
  output logic            core_done
);
  logic [9:0] held;
  int         cnt;

  initial
  begin
    core_done = 1'b0;
    core_result = 10'h2AA;
  end

  always @(posedge clk)
  begin
    core_done <= 1'b0;
    // Bus toggles when no strobe, so stale data cannot pass
    core_result <= ~core_result;
    if (core_sample)
    begin
      held <= value;
      cnt <= 6;
    end
    else if (core_clk_tick && cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        core_done <= 1'b1;
        core_result <= held;
      end
    end
  end
endmodule // adcc_core_model

// ===== dv/adcc_top_test.sv
/*
  Self-checking bench of adcc_top with the core model on its far side.
  Assumes the checker is bound through its own file.
*/
`timescale 1ns/1ps

module adcc_top_test;
  import adcc_pkg::*;
  typedef struct {logic [7:0] a, w, e;} adcc_row_t;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic global_irq_enable, irq_vector_ack, conversion_done_irq, core_sample, core_long;
  logic core_clk_tick, core_done;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, core_input_channel_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, core_reference_select, rr, br;
  logic [6:0]  trigger_inputs;
  logic [9:0]  core_result, val;
  int          error_cnt, checked, ticks;
  time         t;
  adcc_row_t   rows[6] = '{'{8'h10, 8'hCA, 8'hCA}, '{8'h08, 8'hF3, 8'h03}, '{8'h0C, 8'h07, 8'h07},
                           '{8'h00, 8'hFF, 8'h00}, '{8'h04, 8'hFF, 8'h00}, '{8'h14, 8'hFF, 8'h00}};

  adcc_top dut (.*);
  adcc_core_model u_core (.clk(clk), .core_sample(core_sample), .core_clk_tick(core_clk_tick),
                          .value(val), .core_result(core_result), .core_done(core_done));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (!s_axi_bvalid || !s_axi_bready);
    br = s_axi_bresp;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata[7:0];
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic conv(int n);
    int i;
    i = 0;
    while (conversion_done_irq !== 1'b1 && i < 9000)
    begin
      @(posedge clk);
      i++;
    end
    chk("ticks", 10'(n), 10'(ticks));
    chk("long", 10'(n == 25), 10'(core_long));
  endtask

  task automatic ackp;
    @(posedge clk);
    irq_vector_ack <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b0;
  endtask

  task automatic rst6;
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic results;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
    if (core_sample)
      ticks <= core_clk_tick ? 1 : 0;
    else if (core_clk_tick)
      ticks <= ticks + 1;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run needs about 72k cycles, most of it reference settling
  initial
  begin
    #2ms;
    error_cnt++;
    results;
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq_vector_ack} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, trigger_inputs, val} = '0;
    {sys_rst, global_irq_enable, s_axi_wstrb} = 6'h3F;
    rst6;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk("reg", rows[i].e, d);
      chk("rresp", (rows[i].a > 8'h10) ? 10'h2 : 10'h0, rr);
      chk("bresp", (rows[i].a > 8'h10) ? 10'h2 : 10'h0, br);
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h0C, 8'h80 | 8'(c));
      repeat (2) @(posedge core_clk_tick);
      t = $time;
      @(posedge core_clk_tick);
      chk("div", (c < 2) ? 10'd2 : 10'(1 << c), 10'(($time - t) / 20));
    end
    $display("registers and divider done");
    wr(8'h10, 8'h8E);
    repeat (50000) @(posedge clk);
    val = 10'h2C7;
    wr(8'h0C, 8'hCF);
    rd(8'h0C, d);
    chk("busy", 8'hCF, d);
    conv(25);
    chk("chan", 4'hE, core_input_channel_select);
    chk("ref", 2'h2, core_reference_select);
    rd(8'h00, d);
    chk("low", 8'hC7, d);
    rd(8'h04, d);
    chk("high", 8'h02, d);
    rd(8'h0C, d);
    chk("flag", 8'h9F, d);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    chk("mask", 0, conversion_done_irq);
    global_irq_enable <= 1'b1;
    wr(8'h0C, 8'h9F);
    rd(8'h0C, d);
    chk("w1c", 8'h8F, d);
    wr(8'h08, 8'h08);
    rd(8'h00, d);
    chk("ljlow", 8'hC0, d);
    rd(8'h04, d);
    chk("ljhigh", 8'hB1, d);
    val = 10'h155;
    wr(8'h0C, 8'hCF);
    conv(13);
    ackp;
    repeat (2) @(posedge clk);
    chk("ack", 0, conversion_done_irq);
    rd(8'h00, d);
    val = 10'h3FF;
    wr(8'h0C, 8'hCF);
    conv(13);
    ackp;
    rd(8'h04, d);
    chk("lock", 8'h55, d);
    $display("conversions done");
    wr(8'h0C, 8'hCF);
    wr(8'h10, 8'h41);
    chk("refhold", 2'h2, core_reference_select);
    chk("chanhold", 4'hE, core_input_channel_select);
    conv(13);
    ackp;
    wr(8'h0C, 8'hCF);
    conv(25);
    chk("refnew", 2'h1, core_reference_select);
    chk("channew", 4'h1, core_input_channel_select);
    ackp;
    wr(8'h0C, 8'hCF);
    repeat (300) @(posedge clk);
    wr(8'h0C, 8'h0F);
    repeat (4000) @(posedge clk);
    chk("abort", 0, conversion_done_irq);
    chk("tickoff", 0, core_clk_tick);
    rd(8'h0C, d);
    chk("off", 8'h0F, d);
    wr(8'h08, 8'h01);
    wr(8'h0C, 8'hAF);
    trigger_inputs <= 7'h01;
    conv(25);
    trigger_inputs <= 7'h00;
    ackp;
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'hEF);
    wait (conversion_done_irq === 1'b1);
    rd(8'h0C, d);
    chk("freerun", 8'hFF, d);
    $display("abort, trigger and free running done");
    rst6;
    for (int a = 0; a < 5; a++)
    begin
      rd(8'(a * 4), d);
      chk("rst", 0, d);
    end
    $display("reset done");
    results;
  end
endmodule // adcc_top_test
